//--- src/image_decoder_pkg.sv
// Shared constants and carrier types for the raster image decoder.
// Assumes one clock domain; included by every design file by scoped name.
package image_decoder_pkg;

    // ------------------------------------------------------------------
    // Header layout, byte positions from the start of the image.
    // ------------------------------------------------------------------
    localparam logic [2:0] HDR_WIDTH    = 3'h0;
    localparam logic [2:0] HDR_HEIGHT   = 3'h1;
    localparam logic [2:0] HDR_BPP      = 3'h2;
    localparam logic [2:0] HDR_COUNT    = 3'h3;
    localparam logic [2:0] HDR_LOC_HI   = 3'h4;
    localparam logic [2:0] HDR_LOC_LO   = 3'h5;
    localparam logic [2:0] HDR_LEN_MONO = 3'h2;
    localparam logic [2:0] HDR_LEN_COL  = 3'h6;

    // ------------------------------------------------------------------
    // Colour table and body limits.
    // ------------------------------------------------------------------
    localparam logic [3:0] BPP_MIN      = 4'h1;
    localparam logic [3:0] BPP_MAX      = 4'h8;
    localparam logic [8:0] COUNT_ZERO   = 9'h100;
    localparam logic [1:0] ENTRY_BYTES  = 2'h3;
    localparam logic [7:0] FULL_LEVEL   = 8'hFF;
    localparam int         FIFO_DEPTH   = 32;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_HDR   = 3'h1,
        ST_FETCH = 3'h3,
        ST_BITS  = 3'h2,
        ST_TBL   = 3'h6,
        ST_PUSH  = 3'h7,
        ST_DONE  = 3'h5,
        ST_FAIL  = 3'h4
    } state_t;

    typedef struct packed {
        logic       set;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pixel_t;

    typedef struct packed {
        logic [7:0]  width;
        logic [7:0]  height;
        logic [7:0]  bpp;
        logic [7:0]  count;
        logic [15:0] tblOffset;
    } header_t;

endpackage

//--- src/raster_image_decoder.sv
// Raster image decoder: reads an image instance byte by byte from a file
// store and streams pixels in raster order through an output FIFO.
// Assumes the store answers each accepted read with one response pulse at
// least one cycle later, one read outstanding at a time.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Pixel FIFO.
// ----------------------------------------------------------------------
module pixel_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      wrPtr_nxt;
    logic [AW:0]      rdPtr_r;
    logic [AW:0]      rdPtr_nxt;

    // Full when pointers differ only in the wrap bit.
    assign inReady  = (wrPtr_r != {~rdPtr_r[AW], rdPtr_r[AW-1:0]});
    assign outValid = (wrPtr_r != rdPtr_r);
    assign outData  = mem[rdPtr_r[AW-1:0]];

    // Pointer advance; a flush drops everything still queued.
    always_comb
    begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        if (inValid && inReady)
            wrPtr_nxt = wrPtr_r + 1'b1;
        if (outValid && outReady)
            rdPtr_nxt = rdPtr_r + 1'b1;
        if (flush)
        begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else
        begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
        end
    end

    // Storage has no reset; it is only read behind a valid pointer.
    always_ff @(posedge clock)
    begin
        if (inValid && inReady)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end
endmodule

// ----------------------------------------------------------------------
// Decoder top.
// ----------------------------------------------------------------------
module raster_image_decoder #(
    parameter int AW    = 16,
    parameter int DEPTH = image_decoder_pkg::FIFO_DEPTH
) (
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    input  wire logic                      start,
    input  wire logic                      colourMode,
    input  wire logic [AW-1:0]             fileBase,
    input  wire logic [AW-1:0]             imageStart,
    output logic                           memReqValid,
    input  wire logic                      memReqReady,
    output logic      [AW-1:0]             memReqAddr,
    input  wire logic                      memRspValid,
    input  wire logic [7:0]                memRspData,
    output logic                           pixValid,
    input  wire logic                      pixReady,
    output image_decoder_pkg::pixel_t      pixData,
    output logic                           busy,
    output logic                           done,
    output logic                           error
);
    image_decoder_pkg::state_t  state_r,    state_nxt;
    image_decoder_pkg::header_t hdr_r,      hdr_nxt;
    image_decoder_pkg::pixel_t  pix_r,      pix_nxt;
    logic                       mode_r,     mode_nxt;
    logic                       pend_r,     pend_nxt;
    logic [2:0]                 hdrIdx_r,   hdrIdx_nxt;
    logic [1:0]                 tblIdx_r,   tblIdx_nxt;
    logic [7:0]                 byte_r,     byte_nxt;
    logic [3:0]                 bitsLeft_r, bitsLeft_nxt;
    logic [3:0]                 got_r,      got_nxt;
    logic [7:0]                 idx_r,      idx_nxt;
    logic [AW-1:0]              bodyAddr_r, bodyAddr_nxt;
    logic [AW-1:0]              base_r,     base_nxt;
    logic [AW-1:0]              file_r,     file_nxt;
    logic [15:0]                pushCnt_r,  pushCnt_nxt;
    logic [15:0]                outCnt_r,   outCnt_nxt;
    logic                       done_r,     done_nxt;
    logic                       err_r,      err_nxt;

    logic       rsp;
    logic       fifoInValid;
    logic       fifoInReady;
    logic       flush;
    logic [3:0] bpp;
    logic [8:0] entries;
    logic       hdrBad;
    logic [15:0] total;
    logic [9:0] entryOff;
    logic [2:0] hdrLast;

    // Header interpretation; monochrome images use a fixed one-bit index.
    assign bpp      = mode_r ? hdr_r.bpp[3:0] : 4'h1;
    assign entries  = (hdr_r.count == 8'h00) ? image_decoder_pkg::COUNT_ZERO
                                             : {1'b0, hdr_r.count};
    // A too-large count is caught before the index checks rely on it.
    assign hdrBad   = mode_r && ((hdr_r.bpp < 8'(image_decoder_pkg::BPP_MIN))
                    || (hdr_r.bpp > 8'(image_decoder_pkg::BPP_MAX))
                    || (entries > (9'h001 << bpp)));
    assign total    = hdr_r.width * hdr_r.height;
    assign entryOff = ({2'b00, idx_r} << 1) + {2'b00, idx_r};
    assign hdrLast  = (mode_r ? image_decoder_pkg::HDR_LEN_COL
                              : image_decoder_pkg::HDR_LEN_MONO) - 3'h1;
    assign rsp      = memRspValid && pend_r;

    // Reads go out from the header, body and table states only.
    always_comb
    begin
        memReqAddr = '0;
        case (state_r)
            image_decoder_pkg::ST_HDR:   memReqAddr = base_r + AW'(hdrIdx_r);
            image_decoder_pkg::ST_FETCH: memReqAddr = bodyAddr_r;
            image_decoder_pkg::ST_TBL:   memReqAddr = file_r + AW'(hdr_r.tblOffset)
                                                    + AW'(entryOff) + AW'(tblIdx_r);
            default:                     memReqAddr = '0;
        endcase
    end

    assign memReqValid = !pend_r && ((state_r == image_decoder_pkg::ST_HDR)
                      || (state_r == image_decoder_pkg::ST_TBL)
                      || ((state_r == image_decoder_pkg::ST_FETCH) && !hdrBad
                          && (pushCnt_r != total)));
    assign fifoInValid = (state_r == image_decoder_pkg::ST_PUSH);
    assign flush       = (state_r == image_decoder_pkg::ST_FAIL);
    assign busy        = (state_r != image_decoder_pkg::ST_IDLE);
    assign done        = done_r;
    assign error       = err_r;

    // Decoder sequencing: header, then per point gather bits, look up (colour mode only), push.
    always_comb
    begin
        state_nxt    = state_r;
        hdr_nxt      = hdr_r;
        pix_nxt      = pix_r;
        mode_nxt     = mode_r;
        pend_nxt     = pend_r;
        hdrIdx_nxt   = hdrIdx_r;
        tblIdx_nxt   = tblIdx_r;
        byte_nxt     = byte_r;
        bitsLeft_nxt = bitsLeft_r;
        got_nxt      = got_r;
        idx_nxt      = idx_r;
        bodyAddr_nxt = bodyAddr_r;
        base_nxt     = base_r;
        file_nxt     = file_r;
        pushCnt_nxt  = pushCnt_r;
        outCnt_nxt   = outCnt_r;
        done_nxt     = 1'b0;
        err_nxt      = err_r;
        if (memReqValid && memReqReady)
            pend_nxt = 1'b1;
        if (rsp)
            pend_nxt = 1'b0;
        if (pixValid && pixReady)
            outCnt_nxt = outCnt_r + 16'h0001;
        case (state_r)
            image_decoder_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    mode_nxt     = colourMode;
                    base_nxt     = imageStart;
                    file_nxt     = fileBase;
                    hdr_nxt      = '0;
                    hdrIdx_nxt   = '0;
                    bitsLeft_nxt = '0;
                    got_nxt      = '0;
                    idx_nxt      = '0;
                    pushCnt_nxt  = '0;
                    outCnt_nxt   = '0;
                    err_nxt      = 1'b0;
                    state_nxt    = image_decoder_pkg::ST_HDR;
                end
            end
            image_decoder_pkg::ST_HDR:
            begin
                if (rsp)
                begin
                    case (hdrIdx_r)
                        image_decoder_pkg::HDR_WIDTH:  hdr_nxt.width  = memRspData;
                        image_decoder_pkg::HDR_HEIGHT: hdr_nxt.height = memRspData;
                        image_decoder_pkg::HDR_BPP:    hdr_nxt.bpp    = memRspData;
                        image_decoder_pkg::HDR_COUNT:  hdr_nxt.count  = memRspData;
                        image_decoder_pkg::HDR_LOC_HI:
                            hdr_nxt.tblOffset[15:8] = memRspData;
                        image_decoder_pkg::HDR_LOC_LO:
                            hdr_nxt.tblOffset[7:0]  = memRspData;
                        default: hdr_nxt = hdr_r;
                    endcase
                    hdrIdx_nxt = hdrIdx_r + 3'h1;
                    if (hdrIdx_r == hdrLast)
                    begin
                        bodyAddr_nxt = base_r + AW'(hdrIdx_r) + 1'b1;
                        state_nxt    = image_decoder_pkg::ST_FETCH;
                    end
                end
            end
            image_decoder_pkg::ST_FETCH:
            begin
                if (hdrBad)
                    state_nxt = image_decoder_pkg::ST_FAIL;
                else if (pushCnt_r == total)
                    state_nxt = image_decoder_pkg::ST_DONE;
                else if (rsp)
                begin
                    byte_nxt     = memRspData;
                    bitsLeft_nxt = 4'h8;
                    bodyAddr_nxt = bodyAddr_r + 1'b1;
                    state_nxt    = image_decoder_pkg::ST_BITS;
                end
            end
            image_decoder_pkg::ST_BITS:
            begin
                // One bit per cycle keeps the unpacker small; index fields may
                // straddle byte boundaries without any special case.
                if (got_r == bpp)
                begin
                    if (!mode_r)
                    begin
                        pix_nxt       = '0;
                        pix_nxt.set   = idx_r[0];
                        state_nxt     = image_decoder_pkg::ST_PUSH;
                    end
                    else if ({1'b0, idx_r} >= entries)
                        state_nxt = image_decoder_pkg::ST_FAIL;
                    else
                    begin
                        tblIdx_nxt = '0;
                        state_nxt  = image_decoder_pkg::ST_TBL;
                    end
                end
                else if (bitsLeft_r == 4'h0)
                    state_nxt = image_decoder_pkg::ST_FETCH;
                else
                begin
                    idx_nxt      = {idx_r[6:0], byte_r[7]};
                    byte_nxt     = {byte_r[6:0], 1'b1};
                    bitsLeft_nxt = bitsLeft_r - 4'h1;
                    got_nxt      = got_r + 4'h1;
                end
            end
            image_decoder_pkg::ST_TBL:
            begin
                if (rsp)
                begin
                    case (tblIdx_r)
                        2'h0:    pix_nxt.red   = memRspData;
                        2'h1:    pix_nxt.green = memRspData;
                        default: pix_nxt.blue  = memRspData;
                    endcase
                    pix_nxt.set = 1'b1;
                    tblIdx_nxt  = tblIdx_r + 2'h1;
                    if (tblIdx_r == image_decoder_pkg::ENTRY_BYTES - 2'h1)
                        state_nxt = image_decoder_pkg::ST_PUSH;
                end
            end
            image_decoder_pkg::ST_PUSH:
            begin
                if (fifoInReady)
                begin
                    pushCnt_nxt = pushCnt_r + 16'h0001;
                    got_nxt     = '0;
                    idx_nxt     = '0;
                    // Leftover bits in the byte carry over to the next index; only those after the last pixel go unread.
                    state_nxt   = (pushCnt_nxt == total) ? image_decoder_pkg::ST_DONE
                                                         : image_decoder_pkg::ST_BITS;
                end
            end
            image_decoder_pkg::ST_DONE:
            begin
                if (outCnt_nxt == total)
                begin
                    done_nxt  = 1'b1;
                    state_nxt = image_decoder_pkg::ST_IDLE;
                end
            end
            image_decoder_pkg::ST_FAIL:
            begin
                // Queued pixels are flushed this cycle, so none leave afterwards.
                err_nxt   = 1'b1;
                state_nxt = image_decoder_pkg::ST_IDLE;
            end
            default: state_nxt = image_decoder_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r    <= image_decoder_pkg::ST_IDLE;
            hdr_r      <= '0;
            pix_r      <= '0;
            mode_r     <= 1'b0;
            pend_r     <= 1'b0;
            hdrIdx_r   <= '0;
            tblIdx_r   <= '0;
            byte_r     <= '0;
            bitsLeft_r <= '0;
            got_r      <= '0;
            idx_r      <= '0;
            bodyAddr_r <= '0;
            base_r     <= '0;
            file_r     <= '0;
            pushCnt_r  <= '0;
            outCnt_r   <= '0;
            done_r     <= 1'b0;
            err_r      <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            hdr_r      <= hdr_nxt;
            pix_r      <= pix_nxt;
            mode_r     <= mode_nxt;
            pend_r     <= pend_nxt;
            hdrIdx_r   <= hdrIdx_nxt;
            tblIdx_r   <= tblIdx_nxt;
            byte_r     <= byte_nxt;
            bitsLeft_r <= bitsLeft_nxt;
            got_r      <= got_nxt;
            idx_r      <= idx_nxt;
            bodyAddr_r <= bodyAddr_nxt;
            base_r     <= base_nxt;
            file_r     <= file_nxt;
            pushCnt_r  <= pushCnt_nxt;
            outCnt_r   <= outCnt_nxt;
            done_r     <= done_nxt;
            err_r      <= err_nxt;
        end
    end

    // Output buffering; a stalled consumer backs up into the push state.
    pixel_fifo #(
        .WIDTH ($bits(image_decoder_pkg::pixel_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock    (clock),
        .arst_n   (arst_n),
        .flush    (flush),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (pix_r),
        .outValid (pixValid),
        .outReady (pixReady),
        .outData  (pixData)
    );
endmodule

//--- verif/raster_image_decoder_chk.sv
// Checker for the raster image decoder, bound to the top module's ports.
// Assumes one clock domain and the store handshake of the decoder.
`timescale 1ns/1ps
module raster_image_decoder_chk #(
    parameter int AW = 16
) (
    input wire logic                      clock,
    input wire logic                      arst_n,
    input wire logic                      start,
    input wire logic [AW-1:0]             imageStart,
    input wire logic                      memReqValid,
    input wire logic                      memReqReady,
    input wire logic [AW-1:0]             memReqAddr,
    input wire logic                      memRspValid,
    input wire logic                      pixValid,
    input wire logic                      pixReady,
    input wire image_decoder_pkg::pixel_t pixData,
    input wire logic                      busy,
    input wire logic                      done,
    input wire logic                      error
);
    logic pendR;
    logic pendNxt;

    // ------------------------------------------------------------------
    // Reads outstanding.
    // ------------------------------------------------------------------
    always_comb
    begin
        pendNxt = pendR;
        if (memReqValid && memReqReady)
            pendNxt = 1'b1;
        else if (memRspValid)
            pendNxt = 1'b0;
    end

    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            pendR <= 1'b0;
        else
            pendR <= pendNxt;

    // ------------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_launch;
        start && !busy;
    endsequence
    sequence s_accept;
        memReqValid && memReqReady;
    endsequence

    property p_launch;
        s_launch |=> busy && !error && memReqValid && memReqAddr == $past(imageStart);
    endproperty
    property p_req_hold;
        memReqValid && !memReqReady |=> memReqValid && $stable(memReqAddr);
    endproperty
    property p_req_drop;
        s_accept |=> !memReqValid;
    endproperty
    property p_one_out;
        memReqValid |-> !pendR;
    endproperty
    property p_done_pulse;
        done |=> !done;
    endproperty
    property p_done_busy;
        done |-> !busy && $past(busy);
    endproperty
    property p_err_quiet;
        error |=> !pixValid && !done;
    endproperty
    property p_pix_hold;
        pixValid && !pixReady && !error |=> error || (pixValid && $stable(pixData));
    endproperty
    property p_idle;
        !busy |-> !memReqValid;
    endproperty

    a_launch: assert property (p_launch) else $error("no header read");
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    a_req_drop: assert property (p_req_drop) else $error("request kept");
    a_one_out: assert property (p_one_out) else $error("two reads out");
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    a_done_busy: assert property (p_done_busy) else $error("busy at done");
    a_err_quiet: assert property (p_err_quiet) else $error("output after error");
    a_pix_hold: assert property (p_pix_hold) else $error("stalled pixel moved");
    a_idle: assert property (p_idle) else $error("read while idle");
endmodule

bind raster_image_decoder raster_image_decoder_chk #(.AW(AW)) raster_image_decoder_chk_inst (
    .clock(clock), .arst_n(arst_n), .start(start), .imageStart(imageStart),
    .memReqValid(memReqValid), .memReqReady(memReqReady), .memReqAddr(memReqAddr),
    .memRspValid(memRspValid), .pixValid(pixValid), .pixReady(pixReady),
    .pixData(pixData), .busy(busy), .done(done), .error(error)
);

//--- verif/image_store.sv
// Behavioural file store answering the decoder's byte reads.
// Assumes the bench fills mem directly.
`timescale 1ns/1ps
module image_store (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        slow,
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic [15:0] reqAddr,
    output logic             rspValid,
    output logic      [7:0]  rspData
);
    logic [7:0]  mem [0:2047];
    logic [15:0] addr;
    logic        pend;
    int          delay;
    int          seed = 32'h37848E80;

    // ------------------------------------------------------------------
    // Read port; idle data flips every cycle so stale bytes never match.
    // ------------------------------------------------------------------
    always @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData  <= 8'h00;
            pend     <= 1'b0;
            delay    <= 0;
        end
        else
        begin
            rspValid <= 1'b0;
            rspData  <= ~rspData;
            reqReady <= !slow || ($random(seed) % 2 == 0);
            if (pend)
            begin
                if (delay == 0)
                begin
                    rspValid <= 1'b1;
                    rspData  <= mem[addr[10:0]];
                    pend     <= 1'b0;
                end
                else
                    delay <= delay - 1;
            end
            else if (reqValid && reqReady)
            begin
                pend  <= 1'b1;
                addr  <= reqAddr;
                delay <= slow ? $unsigned($random(seed)) % 4 : 0;
            end
        end
endmodule

//--- verif/raster_image_decoder_test.sv
// Self-checking bench for the raster image decoder.
// Assumes the store model and a table at 0300.
`timescale 1ns/1ps
module raster_image_decoder_test;
    localparam logic [15:0] TBL_OFF = 16'h0200;
    logic clock, arst_n, start, colourMode, memReqValid, memReqReady, memRspValid;
    logic pixValid, pixReady, busy, done, error, slow, hold;
    logic [15:0] fileBase, imageStart, memReqAddr;
    logic [7:0]  memRspData;
    image_decoder_pkg::pixel_t pixData;
    image_decoder_pkg::pixel_t expQ[$];
    int seed = 32'h37848E80;
    int errTotal = 0;
    int nCompared = 0;
    int cycles = 0;

    raster_image_decoder raster_image_decoder_inst (
        .clock(clock), .arst_n(arst_n), .start(start), .colourMode(colourMode),
        .fileBase(fileBase), .imageStart(imageStart), .memReqValid(memReqValid),
        .memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
        .memRspData(memRspData), .pixValid(pixValid), .pixReady(pixReady),
        .pixData(pixData), .busy(busy), .done(done), .error(error));
    image_store image_store_inst (
        .clock(clock), .arst_n(arst_n), .slow(slow), .reqValid(memReqValid),
        .reqReady(memReqReady), .reqAddr(memReqAddr), .rspValid(memRspValid),
        .rspData(memRspData));

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (errTotal == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic put(input int a, input logic [7:0] v);
        image_store_inst.mem[a % 2048] = v;
    endtask

    // Builds an image and queues its pixels; a bad image queues none.
    task automatic make_img(input int st, input bit col, input int w, h, b, c, input bit bad);
        int p, v, q, t;
        p = col ? 6 : 2;
        put(st, w[7:0]);
        put(st + 1, h[7:0]);
        put(st + 2, b[7:0]);
        put(st + 3, c[7:0]);
        put(st + 4, TBL_OFF[15:8]);
        put(st + 5, TBL_OFF[7:0]);
        for (int i = 0; i < (w * h * b + 7) / 8; i++)
            put(st + p + i, 8'hFF); // Pad bits stay one.
        for (int i = 0; i < w * h; i++)
        begin
            v = bad ? c : $unsigned($random(seed)) % (c == 0 ? 256 : c);
            for (int k = b - 1; k >= 0; k--)
            begin
                q = i * b + b - 1 - k; // Top bit first.
                image_store_inst.mem[(st + p + q / 8) % 2048][7 - q % 8] = v[k];
            end
            t = 16'h0300 + 3 * v;
            if (!bad)
                expQ.push_back(col ? {1'b1, image_store_inst.mem[t],
                    image_store_inst.mem[t + 1], image_store_inst.mem[t + 2]} : {v[0], 24'h0});
        end
    endtask

    // Starts one decode and waits, bounded, for done or error.
    task automatic run(input logic [15:0] st, input bit col, input int w, h, b, c, input bit bad);
        int t;
        t = 0;
        make_img(st, col, w, h, b, c, bad);
        slow = ($random(seed) % 2) != 0;
        fileBase = 16'h0100;
        start = 1'b1;
        colourMode = col;
        imageStart = st;
        @(posedge clock);
        #1;
        start = 1'b0;
        colourMode = ~col;
        fileBase = 16'($random(seed));
        imageStart = 16'($random(seed));
        while (done !== 1'b1 && error !== 1'b1 && t < 5000)
        begin
            @(posedge clock);
            #1;
            t++;
        end
        check(error, bad);
        check(done, !bad);
        check(expQ.size() == 0, 1'b1);
        repeat (4) @(posedge clock);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Clock, consumer, pixel monitor and hang guard.
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (arst_n && pixValid === 1'b1 && pixReady === 1'b1)
            check(pixData, expQ.size() ? expQ.pop_front() : 25'hx);
        cycles++;
        if (cycles == 60000)
        begin
            errTotal++;
            tally_and_finish();
        end
        #1 pixReady = !hold && ($random(seed) % 4 != 0);
    end

    // ------------------------------------------------------------------
    // Scenarios: fixed corners, then random images.
    // ------------------------------------------------------------------
    initial
    begin
        int b, c;
        bit m;
        arst_n = 1'b0; start = 1'b0; colourMode = 1'b0; fileBase = 16'h0100;
        imageStart = 16'h0000; pixReady = 1'b0; slow = 1'b0; hold = 1'b0;
        repeat (6) @(posedge clock);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 768; i++)
            put(16'h0300 + i, 8'($random(seed)));
        run(16'h0110, 0, 3, 3, 1, 2, 0);
        run(16'h0120, 1, 3, 2, 3, 5, 0);
        run(16'h0140, 1, 2, 5, 2, 4, 0);
        run(16'h0160, 1, 2, 2, 8, 0, 0);
        run(16'h0110, 1, 2, 2, 9, 1, 1);
        run(16'h0110, 1, 2, 2, 0, 1, 1);
        run(16'h0110, 1, 2, 2, 2, 5, 1);
        run(16'h0110, 1, 1, 1, 2, 3, 1);
        run(16'h0110, 0, 0, 4, 1, 2, 0);
        hold = 1'b1;
        fork
            run(16'h0110, 0, 8, 8, 1, 2, 0);
            begin
                repeat (300) @(posedge clock);
                #2;
                check(pixValid, 1'b1);
                check(busy, 1'b1);
                hold = 1'b0;
            end
        join
        for (int r = 0; r < 8; r++)
        begin
            m = ($random(seed) % 2) != 0;
            b = m ? 1 + $unsigned($random(seed)) % 8 : 1;
            c = m ? (1 + $unsigned($random(seed)) % (1 << b)) % 256 : 2;
            run(16'h0180, m, 1 + $unsigned($random(seed)) % 6,
                1 + $unsigned($random(seed)) % 6, b, c, 0);
        end
        tally_and_finish();
    end
endmodule
